// >>> bsc_regs.sv
// Bias and system control register bank with APB slave and checksum unit
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1: Bias level bit 7 picks half supply span at 0, one twelfth at 1.
// R2: Bias generator stays off unless at least one connect bit is set.
// R3: Bit 6 connects bias to common input; bits 5..0 to inputs 5..0.
// R4: Any combination of connect bits may be set together.
// R5: Monitor field 000 off, 001 mid short, 010 temperature, 011/100 supplies.
// R6: Supply monitor codes force amplifier gain to one; others keep user gain.
// R7: Host enables the amplifier with code 01 before selecting temperature.
// R8: Monitor codes 101,110,111 enable burn-out sources 0.2, 1, 10 microamps.
// R9: Averaging field picks 1, 4, 8 or 16 calibration samples, reset 8.
// R10: Bit 2 enables the serial timeout; reset leaves it off.
// R11: Bit 1 appends a checksum byte after each result; off by default.
// R12: Checksum covers the 16-bit result, plus status byte when enabled.
// R13: Bit 0 prepends a status byte to each result; off by default.
// R14: Bias register at index 08h, all bits read/write, reset 00h.
// R15: System control at index 09h, read/write, reset 10h.
// R16: Mid short, temperature and supply monitors open the input multiplexer.
// R17: Host keeps gain at four or less for temperature measurement.
module bsc_regs
  import bsc_pkg::*;
(
  input  wire logic        clk,              // 125 MHz clock
  input  wire logic        rstn,             // Synchronous reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB write
  input  wire logic [11:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output var  logic [31:0] prdata,           // APB read data
  output var  logic        pready,           // APB ready
  output var  logic        pslverr,          // APB error on unmapped address
  input  wire logic        result_valid,     // Conversion result strobe
  input  wire logic [15:0] result_data,      // Conversion result
  input  wire logic [7:0]  status_data,      // Status byte of the result
  output var  logic        bias_level_select,// 1: span/12, 0: span/2
  output var  logic        bias_gen_enable,  // Bias generator on
  output var  logic [6:0]  bias_connect,     // [6] common input, [5:0] inputs
  output var  logic        mid_short_enable, // Amplifier inputs at mid supply
  output var  logic        temp_sensor_enable,// Temperature sensor selected
  output var  logic        asupply_mon_enable,// Analog span /4 selected
  output var  logic        dsupply_mon_enable,// Digital supply /4 selected
  output var  logic [1:0]  burnout_level,    // Burn-out source level
  output var  logic        force_gain_one,   // Override user gain to one
  output var  logic        input_mux_open,   // Open input multiplexer switches
  output var  logic [4:0]  cal_sample_count, // Calibration samples averaged
  output var  logic        timeout_enable,   // Serial timeout on
  output var  logic        checksum_enable,  // Append checksum byte
  output var  logic        status_byte_enable,// Prepend status byte
  output var  logic [2:0]  frame_bytes,      // Bytes per result readout
  output var  logic [7:0]  checksum_byte,    // Checksum of the last result
  output var  logic        checksum_valid    // One-cycle checksum strobe
);

  function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ BSC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_byte

  function automatic logic [1:0] addr_sel(input logic [11:0] a);
    if (a[11:10] == 2'b00 && a[9:0] == BSC_ADDR_BIAS) begin
      return 2'd1;
    end else if (a[11:10] == 2'b00 && a[9:0] == BSC_ADDR_SYS) begin
      return 2'd2;
    end
    return 2'd0;
  endfunction : addr_sel

  logic [7:0]  bias_reg, bias_next;
  logic [7:0]  sys_reg, sys_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        level_reg, level_next;
  logic        gen_reg, gen_next;
  logic [6:0]  conn_reg, conn_next;
  logic        mid_reg, mid_next;
  logic        temp_reg, temp_next;
  logic        asup_reg, asup_next;
  logic        dsup_reg, dsup_next;
  logic [1:0]  bo_reg, bo_next;
  logic        gain1_reg, gain1_next;
  logic        mux_reg, mux_next;
  logic [4:0]  cal_reg, cal_next;
  logic        tmo_reg, tmo_next;
  logic        crcen_reg, crcen_next;
  logic        stat_reg, stat_next;
  logic [2:0]  fbytes_reg, fbytes_next;
  logic [7:0]  cks_reg, cks_next;
  logic        cksv_reg, cksv_next;
  logic        wr_fire;
  logic [1:0]  sel;
  logic [2:0]  mon;

  assign sel     = addr_sel(paddr);
  assign wr_fire = psel & penable & pready_reg & pwrite;
  assign mon     = sys_reg[BSC_MON_MSB:BSC_MON_LSB];

  // APB slave: one wait state, data and ready from flops
  always_comb begin
    pready_next  = psel & penable & ~pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && penable && !pready_reg) begin
      pslverr_next = (sel == 2'd0);
      case (sel)
        2'd1:    prdata_next = {24'h000000, bias_reg};
        2'd2:    prdata_next = {24'h000000, sys_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
    bias_next = bias_reg;
    sys_next  = sys_reg;
    if (wr_fire && sel == 2'd1) begin
      bias_next = pwdata[7:0];                                   // R14
    end
    if (wr_fire && sel == 2'd2) begin
      sys_next = pwdata[7:0];                                    // R15
    end
  end

  // Decode of the two registers into control outputs
  always_comb begin
    level_next = bias_reg[BSC_BIAS_LEVEL_BIT];                   // R1
    conn_next  = bias_reg[BSC_BIAS_COM_BIT:0];                   // R3 R4
    gen_next   = |bias_reg[BSC_BIAS_COM_BIT:0];                  // R2
    mid_next   = (mon == BSC_MON_MIDSHORT);                      // R5
    temp_next  = (mon == BSC_MON_TEMP);                          // R5
    asup_next  = (mon == BSC_MON_ASUPPLY);                       // R5
    dsup_next  = (mon == BSC_MON_DSUPPLY);                       // R5
    gain1_next = asup_next | dsup_next;                          // R6
    mux_next   = mid_next | temp_next | asup_next | dsup_next;   // R16
    case (mon)                                                   // R8
      BSC_MON_BO_LOW:  bo_next = BSC_BO_0U2;
      BSC_MON_BO_MID:  bo_next = BSC_BO_1U;
      BSC_MON_BO_HIGH: bo_next = BSC_BO_10U;
      default:         bo_next = BSC_BO_OFF;
    endcase
    case (sys_reg[BSC_CAL_MSB:BSC_CAL_LSB])                      // R9
      2'd0:    cal_next = BSC_CAL_N0;
      2'd1:    cal_next = BSC_CAL_N1;
      2'd2:    cal_next = BSC_CAL_N2;
      default: cal_next = BSC_CAL_N3;
    endcase
    tmo_next    = sys_reg[BSC_TIMEOUT_BIT];                      // R10
    crcen_next  = sys_reg[BSC_CHECKSUM_BIT];                     // R11
    stat_next   = sys_reg[BSC_STATUS_BIT];                       // R13
    fbytes_next = BSC_RESULT_BYTES + {2'b00, crcen_next} + {2'b00, stat_next}; // R11 R13
  end

  // Checksum over status (if sent) then result high and low bytes
  always_comb begin
    logic [7:0] c;
    c         = BSC_CRC_SEED;
    cks_next  = cks_reg;
    cksv_next = 1'b0;
    if (sys_reg[BSC_STATUS_BIT]) begin
      c = crc_byte(c, status_data);                              // R12
    end
    c = crc_byte(c, result_data[15:8]);                          // R12
    c = crc_byte(c, result_data[7:0]);
    if (result_valid && sys_reg[BSC_CHECKSUM_BIT]) begin         // R11
      cks_next  = c;
      cksv_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bias_reg    <= BSC_RST_BIAS;                               // R14
      sys_reg     <= BSC_RST_SYS;                                // R15
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      level_reg   <= 1'b0;
      gen_reg     <= 1'b0;
      conn_reg    <= 7'h00;
      mid_reg     <= 1'b0;
      temp_reg    <= 1'b0;
      asup_reg    <= 1'b0;
      dsup_reg    <= 1'b0;
      bo_reg      <= BSC_BO_OFF;
      gain1_reg   <= 1'b0;
      mux_reg     <= 1'b0;
      cal_reg     <= BSC_CAL_N2;
      tmo_reg     <= 1'b0;
      crcen_reg   <= 1'b0;
      stat_reg    <= 1'b0;
      fbytes_reg  <= BSC_RESULT_BYTES;
      cks_reg     <= 8'h00;
      cksv_reg    <= 1'b0;
    end else begin
      bias_reg    <= bias_next;
      sys_reg     <= sys_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      level_reg   <= level_next;
      gen_reg     <= gen_next;
      conn_reg    <= conn_next;
      mid_reg     <= mid_next;
      temp_reg    <= temp_next;
      asup_reg    <= asup_next;
      dsup_reg    <= dsup_next;
      bo_reg      <= bo_next;
      gain1_reg   <= gain1_next;
      mux_reg     <= mux_next;
      cal_reg     <= cal_next;
      tmo_reg     <= tmo_next;
      crcen_reg   <= crcen_next;
      stat_reg    <= stat_next;
      fbytes_reg  <= fbytes_next;
      cks_reg     <= cks_next;
      cksv_reg    <= cksv_next;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign bias_level_select  = level_reg;
  assign bias_gen_enable    = gen_reg;
  assign bias_connect       = conn_reg;
  assign mid_short_enable   = mid_reg;
  assign temp_sensor_enable = temp_reg;
  assign asupply_mon_enable = asup_reg;
  assign dsupply_mon_enable = dsup_reg;
  assign burnout_level      = bo_reg;
  assign force_gain_one     = gain1_reg;
  assign input_mux_open     = mux_reg;
  assign cal_sample_count   = cal_reg;
  assign timeout_enable     = tmo_reg;
  assign checksum_enable    = crcen_reg;
  assign status_byte_enable = stat_reg;
  assign frame_bytes        = fbytes_reg;
  assign checksum_byte      = cks_reg;
  assign checksum_valid     = cksv_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_bias_gen_off: assert property (bias_gen_enable |-> |bias_connect) // R2
    else $error("bias generator on with no input connected");
  chk_bias_level_follow: assert property (##1 bias_level_select == $past(bias_reg[BSC_BIAS_LEVEL_BIT])) // R1
    else $error("bias level does not follow register");
  chk_bias_write_lands: assert property (wr_fire && sel == 2'd1 |-> ##2 bias_connect == $past(pwdata[6:0], 2)) // R3
    else $error("bias connect write lost");
  chk_gain_one_force: assert property (force_gain_one |-> asupply_mon_enable || dsupply_mon_enable) // R6
    else $error("gain forced outside supply monitor");
  chk_mux_open_cause: assert property (input_mux_open == (mid_short_enable || temp_sensor_enable // R16
                                       || asupply_mon_enable || dsupply_mon_enable))
    else $error("multiplexer open state wrong");
  chk_burnout_code: assert property (##1 (burnout_level != BSC_BO_OFF) // R8
                                     == $past(mon[2] && mon != BSC_MON_DSUPPLY))
    else $error("burn-out level does not match monitor code");
  chk_cal_reset_eight: assert property ($rose(rstn) |=> cal_sample_count == BSC_CAL_N2) // R9
    else $error("calibration count not eight after reset");
  chk_sys_reset_val: assert property ($rose(rstn) |-> sys_reg == BSC_RST_SYS && bias_reg == BSC_RST_BIAS) // R15
    else $error("register reset values wrong");
  chk_frame_length: assert property (frame_bytes == BSC_RESULT_BYTES + {2'b00, checksum_enable} // R13
                                     + {2'b00, status_byte_enable})
    else $error("frame length wrong");
  chk_checksum_pulse: assert property (result_valid && sys_reg[BSC_CHECKSUM_BIT] |=> checksum_valid) // R11
    else $error("checksum strobe missing");
  chk_no_checksum_off: assert property (result_valid && !sys_reg[BSC_CHECKSUM_BIT] |=> !checksum_valid) // R11
    else $error("checksum sent while disabled");
  chk_timeout_follow: assert property (wr_fire && sel == 2'd2 |-> ##2 timeout_enable == $past(pwdata[2], 2)) // R10
    else $error("timeout enable write lost");
  chk_apb_wait_one: assert property (psel && penable && !pready |=> pready) // R14
    else $error("APB answer not after one wait state");

  // Bus, decode and checksum checks
  chk_bias_gen_track: assert property (##1 bias_gen_enable == $past(|bias_reg[BSC_BIAS_COM_BIT:0])) // R2
    else $error("bias generator enable does not follow connect bits");
  chk_cal_sixteen: assert property (##1 (cal_sample_count == BSC_CAL_N3) // R9
                                    == $past(sys_reg[BSC_CAL_MSB:BSC_CAL_LSB] == 2'h3))
    else $error("sixteen-sample averaging does not follow the field");
  chk_ready_one_cycle: assert property (pready |=> !pready) // R14
    else $error("ready held longer than one cycle");
  chk_unmapped_zero: assert property (pready && pslverr |-> prdata == 32'h00000000) // R14
    else $error("unmapped access returned data");
  chk_unmapped_no_write: assert property (wr_fire && sel == 2'd0 |=> $stable(bias_reg) && $stable(sys_reg)) // R15
    else $error("unmapped write changed a register");
  chk_checksum_hold: assert property (!result_valid |=> $stable(checksum_byte)) // R11
    else $error("checksum byte changed without a result");

  cov_multi_bias: cover property (bias_gen_enable && $countones(bias_connect) > 1);
  cov_temp_sel: cover property (temp_sensor_enable && input_mux_open);
  cov_crc_status: cover property (checksum_valid && status_byte_enable);
  cov_unmapped: cover property (pready && pslverr);
  cov_supply_gain: cover property (force_gain_one && dsupply_mon_enable);

endmodule : bsc_regs

`default_nettype wire

// >>> bsc_pkg.sv
// Constants for the bias and system control register bank
`default_nettype none
package bsc_pkg;
  // Printed register indexes; byte address is four times the index
  localparam logic [7:0] BSC_IDX_BIAS      = 8'h08;
  localparam logic [7:0] BSC_IDX_SYS       = 8'h09;
  localparam logic [9:0] BSC_ADDR_BIAS     = {BSC_IDX_BIAS, 2'b00};
  localparam logic [9:0] BSC_ADDR_SYS      = {BSC_IDX_SYS, 2'b00};
  localparam logic [7:0] BSC_RST_BIAS      = 8'h00;
  localparam logic [7:0] BSC_RST_SYS       = 8'h10;
  // Bias register fields
  localparam int         BSC_BIAS_LEVEL_BIT = 7;
  localparam int         BSC_BIAS_COM_BIT   = 6;
  // System control fields
  localparam int         BSC_MON_MSB       = 7;
  localparam int         BSC_MON_LSB       = 5;
  localparam int         BSC_CAL_MSB       = 4;
  localparam int         BSC_CAL_LSB       = 3;
  localparam int         BSC_TIMEOUT_BIT   = 2;
  localparam int         BSC_CHECKSUM_BIT  = 1;
  localparam int         BSC_STATUS_BIT    = 0;
  // Monitor select codes
  localparam logic [2:0] BSC_MON_OFF       = 3'h0;
  localparam logic [2:0] BSC_MON_MIDSHORT  = 3'h1;
  localparam logic [2:0] BSC_MON_TEMP      = 3'h2;
  localparam logic [2:0] BSC_MON_ASUPPLY   = 3'h3;
  localparam logic [2:0] BSC_MON_DSUPPLY   = 3'h4;
  localparam logic [2:0] BSC_MON_BO_LOW    = 3'h5;
  localparam logic [2:0] BSC_MON_BO_MID    = 3'h6;
  localparam logic [2:0] BSC_MON_BO_HIGH   = 3'h7;
  // Burn-out current level encodings on the output
  localparam logic [1:0] BSC_BO_OFF        = 2'h0;
  localparam logic [1:0] BSC_BO_0U2        = 2'h1;
  localparam logic [1:0] BSC_BO_1U         = 2'h2;
  localparam logic [1:0] BSC_BO_10U        = 2'h3;
  // Calibration averaging counts
  localparam logic [4:0] BSC_CAL_N0        = 5'h01;
  localparam logic [4:0] BSC_CAL_N1        = 5'h04;
  localparam logic [4:0] BSC_CAL_N2        = 5'h08;
  localparam logic [4:0] BSC_CAL_N3        = 5'h10;
  // Checksum: CRC-8, chosen polynomial and seed
  localparam logic [7:0] BSC_CRC_POLY      = 8'h07;
  localparam logic [7:0] BSC_CRC_SEED      = 8'h00;
  // Readout frame byte counts
  localparam logic [2:0] BSC_RESULT_BYTES  = 3'h2;
endpackage : bsc_pkg
`default_nettype wire

// >>> bsc_host_model.sv
// Host controller model: APB master in front of the register bank
`timescale 1ns/1ns
`default_nettype none
module bsc_host_model (
  input  wire logic        clk,     // Bank clock
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Transfer done
  input  wire logic        pslverr, // Transfer error
  output var  logic        psel,    // Select
  output var  logic        penable, // Access phase
  output var  logic        pwrite,  // Direction
  output var  logic [11:0] paddr,   // Byte address
  output var  logic [31:0] pwdata   // Write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // Amplifier setup before temperature readings is left to the user
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // One wait state: answer in the second access cycle
    ok = (n == 2);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : bsc_host_model
`default_nettype wire

// >>> bsc_tb_top.sv
// Self-checking bench for the bias and system control register bank
`timescale 1ns/1ns
`default_nettype none
module bias_and_system_control_regs_tb_top;
  import bsc_pkg::*;
  localparam logic [11:0] AB = {2'b00, BSC_ADDR_BIAS};
  localparam logic [11:0] AS = {2'b00, BSC_ADDR_SYS};
  logic clk = 1'b0, rstn = 1'b0, result_valid = 1'b0;
  logic [15:0] result_data = 16'h0000;
  logic [7:0] status_data = 8'h00;
  logic psel, penable, pwrite, pready, pslverr, bias_level_select, bias_gen_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [6:0] bias_connect;
  logic mid_short_enable, temp_sensor_enable, asupply_mon_enable, dsupply_mon_enable;
  logic [1:0] burnout_level;
  logic force_gain_one, input_mux_open, timeout_enable, checksum_enable;
  logic status_byte_enable, checksum_valid;
  logic [4:0] cal_sample_count;
  logic [2:0] frame_bytes;
  logic [7:0] checksum_byte;
  int errors = 0, n_compared = 0, cycles = 0, seed = 60, eb, es;
  always #4 clk = ~clk;
  bsc_host_model host_u (.clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
  bsc_regs dut_u (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .result_valid, .result_data, .status_data, .bias_level_select, .bias_gen_enable, .bias_connect,
    .mid_short_enable, .temp_sensor_enable, .asupply_mon_enable, .dsupply_mon_enable, .burnout_level,
    .force_gain_one, .input_mux_open, .cal_sample_count, .timeout_enable, .checksum_enable,
    .status_byte_enable, .frame_bytes, .checksum_byte, .checksum_valid);
  task automatic summarize();
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] crc8(input logic [23:0] v, input int nb);
    logic [7:0] c = BSC_CRC_SEED;
    for (int i = nb * 8 - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? BSC_CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  task automatic chk_out();
    int m, c;
    m = es >> 5;
    c = (es >> 3) & 3;
    chk("level", eb >> 7, bias_level_select);
    chk("gen", (eb & 8'h7F) != 0, bias_gen_enable);
    chk("connect", eb & 8'h7F, bias_connect);
    chk("monitor", {m == 1, m == 2, m == 3, m == 4},
        {mid_short_enable, temp_sensor_enable, asupply_mon_enable, dsupply_mon_enable});
    chk("gain_one", m == 3 || m == 4, force_gain_one);
    chk("mux_open", m >= 1 && m <= 4, input_mux_open);
    chk("burnout", m >= 5 ? m - 4 : 0, burnout_level);
    chk("cal", c == 0 ? 1 : 4 << (c - 1), cal_sample_count);
    chk("timeout", (es >> 2) & 1, timeout_enable);
    chk("crc_en", (es >> 1) & 1, checksum_enable);
    chk("stat_en", es & 1, status_byte_enable);
    chk("frame", 2 + ((es >> 1) & 1) + (es & 1), frame_bytes);
  endtask : chk_out
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input int e, input logic ee);
    logic [31:0] r;
    logic er, ok;
    host_u.xfer(w, a, {24'h000000, d}, r, er, ok);
    if (!w) chk("prdata", e, r);
    chk("pslverr", ee, er);
    chk("pready", 1, ok);
  endtask : acc
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 0, 1'b0);
    if (a[2]) es = d;
    else eb = d;
    acc(1'b0, a, 8'h00, a[2] ? es : eb, 1'b0);
    chk_out();
  endtask : wr
  task automatic send(input logic [15:0] r, input logic [7:0] s);
    @(posedge clk);
    result_valid <= 1'b1;
    result_data <= r;
    status_data <= s;
    @(posedge clk);
    result_valid <= 1'b0;
    result_data <= ~r;
    status_data <= ~s;
    @(posedge clk);
    chk("crc_valid", (es >> 1) & 1, checksum_valid);
    if (es & 2) chk("crc_byte", crc8({s, r}, (es & 1) ? 3 : 2), checksum_byte);
  endtask : send
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    eb = BSC_RST_BIAS;
    es = BSC_RST_SYS;
    acc(1'b0, AB, 8'h00, eb, 1'b0);
    acc(1'b0, AS, 8'h00, es, 1'b0);
    chk_out();
    for (int i = 0; i < 8; i++) begin
      rv = $random(seed);
      wr(AB, rv[7:0]);
    end
    wr(AB, 8'h80);
    wr(AB, 8'h7F);
    for (int m = 0; m < 8; m++) begin
      rv = $random(seed);
      wr(AS, {m[2:0], rv[4:0]});
    end
    acc(1'b1, 12'h028, 8'hFF, 0, 1'b1);
    acc(1'b0, 12'h028, 8'h00, 0, 1'b1);
    acc(1'b1, 12'h820, 8'hFF, 0, 1'b1);
    acc(1'b0, 12'h820, 8'h00, 0, 1'b1);
    acc(1'b0, AB, 8'h00, eb, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(AS, {6'h04, k[1:0]});
      rv = $random(seed);
      send(rv[15:0], rv[23:16]);
      send(rv[31:16], rv[7:0]);
    end
    summarize();
  end
endmodule : bias_and_system_control_regs_tb_top
`default_nettype wire
